// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import tmo_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = '0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] op_mode = 2'h0;
  logic [15:0] cmp0 = 16'h5;
  logic [15:0] cmp1 = 16'h9;
  logic [15:0] cnt;
  logic go = 1'b0;
  logic m0, m1, p0_out, p0_oe_n, p1_out, p1_oe_n, tout, pin0, pin1, alt_a, alt_b;
  int err_count = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  tmo_timer_out #(.CNT_W(16), .LARGE_PKG(1'b1)) dut_u (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_mode(op_mode), .compare_reg0(cmp0), .compare_reg1(cmp1),
    .count_value(cnt), .match0_irq(m0), .match1_irq(m1), .port_pin0_in(pin0),
    .port_pin0_out(p0_out), .port_pin0_oe_n(p0_oe_n), .port_pin1_in(pin1),
    .port_pin1_out(p1_out), .port_pin1_oe_n(p1_oe_n), .alt_pin_a(alt_a),
    .alt_pin_b(alt_b), .timer_out_pin(tout));
  tmo_pin_model pm_u (.clk(clk), .go(go), .pin1_out(p1_out), .pin1_oe_n(p1_oe_n),
    .alt_a(alt_a), .alt_b(alt_b), .pin0(pin0), .pin1(pin1));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask : rd
  task automatic wait_m(input bit which);
    int i;
    i = 0;
    while ((which ? m1 : m0) !== 1'b1 && i < 8000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 8000) begin
      err_count++;
      conclude();
    end
  endtask : wait_m
  function automatic logic [7:0] exp_rb(input logic [15:0] a, input logic [7:0] d);
    case (a)
      ADDR_PORT0_DIR: return (d & DIR_STORE_MASK) | DIR_FIXED_ONES;
      ADDR_ALT_SEL: return d;
      ADDR_PRESCALER: return d & PR_STORE_MASK;
      ADDR_OUT_CTRL: return d & OC_STORE_MASK;
      default: return 8'h00;
    endcase
  endfunction : exp_rb
  initial begin
    logic [15:0] ad [5] = '{ADDR_PORT0_DIR, ADDR_ALT_SEL, ADDR_PRESCALER, ADDR_OUT_CTRL,
      16'hff00};
    logic [7:0] seq [8] = '{8'h12, 8'h13, 8'h1b, 8'h1f, 8'h13, 8'h17, 8'h1b, 8'h12};
    logic [7:0] d;
    int i;
    int k;
    int n;
    void'($urandom(91435));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(ad[i]);
      chk(16'(reg_rdata), 16'(exp_rb(ad[i], {8{i == 0}})), "reset value");
    end
    for (i = 0; i < 24; i++) begin
      k = $urandom % 5;
      d = 8'($urandom) & (k == 3 ? 8'h33 : 8'hff);
      wr(ad[k], d);
      rd(ad[k]);
      chk(16'(reg_rdata), 16'(exp_rb(ad[k], d)), "readback");
      if (k == 0) chk(16'({p1_oe_n, p0_oe_n}), 16'(d[1:0]), "direction");
      chk(16'(p0_out), 16'h0, "pin zero out");
    end
    wr(ADDR_PORT0_DIR, 8'hfd);
    // Inversions first, then the enable alone, then presets.
    for (i = 0; i < 8; i++) begin
      wr(ADDR_OUT_CTRL, seq[i]);
      chk(16'(tout), 16'(8'h5c >> i & 8'h1), "timer out");
      chk(16'(pin1), 16'(tout), "pin level");
    end
    rd(ADDR_OUT_CTRL);
    chk(16'(reg_rdata), 16'h12, "control read");
    for (k = 0; k < 3; k++) begin
      cmp0 = 16'h2 + 16'($urandom % 14);
      cmp1 = cmp0 + 16'h3;
      wr(ADDR_PRESCALER, 8'(k));
      wr(ADDR_OUT_CTRL, 8'h13);
      wr(ADDR_OUT_CTRL, 8'(8'h15 | 2 * k[0]));
      op_mode = TMO_MODE_FREE;
      wait_m(1'b0);
      chk(cnt, cmp0 + 16'h1, "count at match");
      chk(16'(tout), 16'(k[0]), "after cmp0");
      wait_m(1'b1);
      chk(16'(tout), 16'(!k[0]), "after cmp1");
      op_mode = TMO_MODE_STOP;
      repeat (2) @(negedge clk);
    end
    cmp0 = 16'h5;
    cmp1 = 16'h3;
    wr(ADDR_PRESCALER, 8'h00);
    wr(ADDR_OUT_CTRL, 8'h37);
    op_mode = TMO_MODE_CMP0_CLR;
    wait_m(1'b0);
    chk(cnt, 16'h0, "cleared on match");
    @(negedge clk);
    wait_m(1'b0);
    chk(16'(tout), 16'h0, "one-shot in mode 3");
    op_mode = TMO_MODE_STOP;
    cmp1 = 16'h9;
    repeat (2) @(negedge clk);
    op_mode = TMO_MODE_FREE;
    wr(ADDR_OUT_CTRL, 8'h73);
    wait_m(1'b0);
    chk(16'(tout), 16'h1, "one-shot start");
    wait_m(1'b1);
    chk(16'(tout), 16'h0, "one-shot end");
    wr(ADDR_ALT_SEL, 8'h10);
    for (k = 0; k < 4; k++) begin
      op_mode = TMO_MODE_STOP;
      wr(ADDR_PRESCALER, 8'(16 * k + 3));
      op_mode = TMO_MODE_FREE;
      n = 1 + $urandom % 6;
      go = 1'b1;
      repeat (8 * n) @(negedge clk);
      go = 1'b0;
      repeat (8) @(negedge clk);
      chk(cnt, 16'(k == 2 ? 0 : (k == 3 ? 2 * n : n)), "event count");
    end
    op_mode = TMO_MODE_STOP;
    conclude();
  end
endmodule : tb_top

// file: tmo_edge_det.sv
`timescale 1ns/100ps
module tmo_edge_det
  import tmo_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  input wire logic run,
  output logic edge_pulse
);

  logic samp_q, samp_d;
  logic lvl_q, lvl_d;
  logic prev_q, prev_d;
  logic first_q, first_d;
  logic rise, fall;

  always_comb begin
    samp_d = pin;
    // A level counts only once it is seen on two samples in a row.
    lvl_d = (samp_q == pin) ? pin : lvl_q;
    if (run) begin
      prev_d = lvl_q;
      first_d = 1'b0;
    end else begin
      // Before the very first start a high level will look like a rising edge.
      prev_d = first_q ? 1'b0 : lvl_q;
      first_d = first_q;
    end
    rise = lvl_q & ~prev_q;
    fall = ~lvl_q & prev_q;
    case (tmo_edge_t'(edge_sel))
      TMO_EDGE_FALL: edge_pulse = run & fall;
      TMO_EDGE_RISE: edge_pulse = run & rise;
      TMO_EDGE_BOTH: edge_pulse = run & (rise | fall);
      default: edge_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_q <= 1'b0;
      lvl_q <= 1'b0;
      prev_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      samp_q <= samp_d;
      lvl_q <= lvl_d;
      prev_q <= prev_d;
      first_q <= first_d;
    end
  end

endmodule : tmo_edge_det

// file: tmo_pin_model.sv
`timescale 1ns/100ps
module tmo_pin_model (
  input wire logic clk,
  input wire logic go,
  input wire logic pin1_out,
  input wire logic pin1_oe_n,
  output logic alt_a,
  output logic alt_b,
  output logic pin0,
  output logic pin1
);
  logic [2:0] ph_q = 3'h0;
  always_ff @(posedge clk) begin
    ph_q <= go ? ph_q + 3'h1 : 3'h0;
  end
  // Pulses stay high four clocks; released lines rise to their pull-up level.
  assign alt_a = go & ph_q[2];
  assign alt_b = 1'b0;
  assign pin0 = 1'b1;
  assign pin1 = pin1_oe_n ? 1'b1 : pin1_out;
endmodule : tmo_pin_model

// file: tmo_pkg.sv
package tmo_pkg;

  // Byte addresses of the registers held by this block.
  localparam logic [15:0] ADDR_PORT0_DIR = 16'hff20;
  localparam logic [15:0] ADDR_ALT_SEL = 16'hff39;
  localparam logic [15:0] ADDR_PRESCALER = 16'hffbb;
  localparam logic [15:0] ADDR_OUT_CTRL = 16'hffbd;

  // Values after reset.
  localparam logic [7:0] RST_PORT0_DIR = 8'hff;
  localparam logic [7:0] RST_ALT_SEL = 8'h00;
  localparam logic [7:0] RST_PRESCALER = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;

  // Output control register fields.
  localparam int OC_TRIG_BIT = 6;
  localparam int OC_OS_SEL_BIT = 5;
  localparam int OC_INV1_BIT = 4;
  localparam int OC_PRE_HI_BIT = 3;
  localparam int OC_PRE_LO_BIT = 2;
  localparam int OC_INV0_BIT = 1;
  localparam int OC_TOE_BIT = 0;
  // Bits of the output control register that are stored.
  localparam logic [7:0] OC_STORE_MASK = 8'h33;

  // Prescaler register fields, each two bits wide starting here.
  localparam int PR_CLK_LO = 0;
  localparam int PR_IN0_EDGE_LO = 4;
  localparam int PR_IN1_EDGE_LO = 6;
  localparam logic [7:0] PR_STORE_MASK = 8'hf3;

  // Input routing field in the alternate select register.
  localparam int ALT_IN0_ROUTE_LO = 4;

  // Port direction register: stored bits and bits that read as one.
  localparam int DIR_PIN0 = 0;
  localparam int DIR_PIN1 = 1;
  localparam logic [7:0] DIR_STORE_MASK = 8'h07;
  localparam logic [7:0] DIR_FIXED_ONES = 8'hf8;

  // Prescaler divider.
  localparam int DIV_W = 8;
  localparam logic [1:0] DIV4_TERM = 2'h3;
  localparam logic [7:0] DIV256_TERM = 8'hff;

  typedef enum logic [1:0] {
    TMO_EDGE_FALL = 2'b00,
    TMO_EDGE_RISE = 2'b01,
    TMO_EDGE_BAD = 2'b10,
    TMO_EDGE_BOTH = 2'b11
  } tmo_edge_t;

  typedef enum logic [1:0] {
    TMO_CLK_PERIPH = 2'b00,
    TMO_CLK_DIV4 = 2'b01,
    TMO_CLK_DIV256 = 2'b10,
    TMO_CLK_IN0 = 2'b11
  } tmo_clk_sel_t;

  typedef enum logic [1:0] {
    TMO_MODE_STOP = 2'b00,
    TMO_MODE_FREE = 2'b01,
    TMO_MODE_IN0_CLR = 2'b10,
    TMO_MODE_CMP0_CLR = 2'b11
  } tmo_mode_t;

  typedef enum logic [1:0] {
    TMO_OS_IDLE = 2'b00,
    TMO_OS_WAIT_SET = 2'b01,
    TMO_OS_WAIT_CLR = 2'b10
  } tmo_os_state_t;

endpackage : tmo_pkg

// file: tmo_timer_out.sv
`timescale 1ns/100ps
module tmo_timer_out
  import tmo_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter bit LARGE_PKG = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] op_mode,
  input wire logic [CNT_W-1:0] compare_reg0,
  input wire logic [CNT_W-1:0] compare_reg1,
  output logic [CNT_W-1:0] count_value,
  output logic match0_irq,
  output logic match1_irq,
  input wire logic port_pin0_in,
  output logic port_pin0_out,
  output logic port_pin0_oe_n,
  input wire logic port_pin1_in,
  output logic port_pin1_out,
  output logic port_pin1_oe_n,
  input wire logic alt_pin_a,
  input wire logic alt_pin_b,
  output logic timer_out_pin
);

  // Counter widths outside this range cannot be served by the compare logic.
  if (CNT_W < 2 || CNT_W > 32) begin : g_check
    $error("tmo_timer_out: CNT_W must lie between 2 and 32");
  end

  // Software visible registers, the prescaler divider and the counter.
  // Each is held in a _q flip-flop and computed as _d in the one process below.
  logic [7:0] dir_q, dir_d;
  logic [7:0] alt_q, alt_d;
  logic [7:0] pre_q, pre_d;
  logic [7:0] oc_q, oc_d;
  logic [7:0] rdata_q, rdata_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic m0_q, m0_d;
  logic m1_q, m1_d;
  tmo_os_state_t os_q, os_d;

  // Decoded controls and single-cycle events of the current clock.
  logic run;
  logic in0_edge, in1_edge;
  logic [1:0] in_pin, in_edge;
  logic timer_in0, timer_in1;
  logic wr_oc;
  logic sw_trig, pre_hi, pre_lo;
  logic tick, match0, match1;
  logic inv0, inv1, toggle;
  logic os_allow0, os_allow1, os_start;
  tmo_mode_t mode;
  tmo_clk_sel_t clk_sel;

  // Mode and clock selection are views of the inputs and of the prescaler register.
  assign mode = tmo_mode_t'(op_mode);
  assign clk_sel = tmo_clk_sel_t'(pre_q[PR_CLK_LO +: 2]);
  assign run = (mode != TMO_MODE_STOP);

  always_comb begin
    // Input zero routing onto port pins.
    // The prohibited routing code and the unrouted code both leave input zero low.
    // A low idle input gives no edge, so a stray routing code cannot count events.
    // The smaller package has a single route bit choosing between two pins.
    if (LARGE_PKG) begin
      case (alt_q[ALT_IN0_ROUTE_LO +: 2])
        2'b01: timer_in0 = alt_pin_a;
        2'b10: timer_in0 = alt_pin_b;
        default: timer_in0 = 1'b0;
      endcase
    end else begin
      timer_in0 = alt_q[ALT_IN0_ROUTE_LO] ? alt_pin_a : port_pin0_in;
    end
    timer_in1 = port_pin1_in;
  end

  // Both timer inputs use the same filter and edge selection, one per input.
  // Their two-bit edge selectors lie side by side in the prescaler register.
  assign in_pin = {timer_in1, timer_in0};

  for (genvar gi = 0; gi < 2; gi++) begin : g_edge
    tmo_edge_det u_edge (
      .clk(clk),
      .rst(rst),
      .pin(in_pin[gi]),
      .edge_sel(pre_q[PR_IN0_EDGE_LO + 2 * gi +: 2]),
      .run(run),
      .edge_pulse(in_edge[gi])
    );
  end

  // Input one edges are decoded here but feed nothing, in this block or at its ports.
  assign in0_edge = in_edge[0];
  assign in1_edge = in_edge[1];

  always_comb begin
    // Trigger bits act on the write itself and are never stored.
    wr_oc = reg_wr && (reg_addr == ADDR_OUT_CTRL);
    sw_trig = wr_oc && reg_wdata[OC_TRIG_BIT];
    pre_hi = wr_oc && reg_wdata[OC_PRE_HI_BIT];
    pre_lo = wr_oc && reg_wdata[OC_PRE_LO_BIT];

    // Count clock enable.
    // The divider runs only while counting, so the first divided tick after a start
    // always lies a full division period away from the start.
    case (clk_sel)
      TMO_CLK_PERIPH: tick = run;
      TMO_CLK_DIV4: tick = run && (div_q[1:0] == DIV4_TERM);
      TMO_CLK_DIV256: tick = run && (div_q == DIV256_TERM);
      TMO_CLK_IN0: tick = in0_edge;
      default: tick = 1'b0;
    endcase

    // A match counts only on a tick, so a stalled counter raises no repeated events.
    match0 = tick && (cnt_q == compare_reg0);
    match1 = tick && (cnt_q == compare_reg1);
    div_d = run ? div_q + 1'b1 : '0;

    // Counter.
    // When input zero is itself the count clock its edges only count, never clear.
    // A software trigger wins over every mode so that a one-shot starts from zero.
    case (mode)
      TMO_MODE_STOP: cnt_d = '0;
      TMO_MODE_FREE: cnt_d = tick ? cnt_q + 1'b1 : cnt_q;
      TMO_MODE_IN0_CLR: begin
        if (in0_edge && clk_sel != TMO_CLK_IN0) begin
          cnt_d = '0;
        end else begin
          cnt_d = tick ? cnt_q + 1'b1 : cnt_q;
        end
      end
      TMO_MODE_CMP0_CLR: begin
        if (match0) begin
          cnt_d = '0;
        end else begin
          cnt_d = tick ? cnt_q + 1'b1 : cnt_q;
        end
      end
      default: cnt_d = '0;
    endcase
    if (sw_trig) begin
      cnt_d = '0;
    end

    // Match events fire whatever the inversion enables say.
    // The inversion enables gate only the output, never the events.
    m0_d = match0;
    m1_d = match1;

    // One-shot sequencing.
    // A start arms the compare zero inversion; its match then arms compare one.
    // After the compare one match the output rests until the next start.
    // Leaving one-shot mode or stopping abandons a pulse that is under way.
    os_start = oc_q[OC_OS_SEL_BIT] && (mode != TMO_MODE_CMP0_CLR) &&
      (sw_trig || (mode == TMO_MODE_IN0_CLR && in0_edge));
    os_d = os_q;
    case (os_q)
      TMO_OS_IDLE: if (os_start) os_d = TMO_OS_WAIT_SET;
      TMO_OS_WAIT_SET: if (match0) os_d = TMO_OS_WAIT_CLR;
      TMO_OS_WAIT_CLR: if (match1) os_d = TMO_OS_IDLE;
      default: os_d = TMO_OS_IDLE;
    endcase
    if (!oc_q[OC_OS_SEL_BIT] || mode == TMO_MODE_STOP || mode == TMO_MODE_CMP0_CLR) begin
      os_d = TMO_OS_IDLE;
    end
    if (oc_q[OC_OS_SEL_BIT]) begin
      os_allow0 = (os_q == TMO_OS_WAIT_SET);
      os_allow1 = (os_q == TMO_OS_WAIT_CLR);
    end else begin
      os_allow0 = 1'b1;
      os_allow1 = 1'b1;
    end

    // Each match inverts the output only when its enable and the one-shot gate agree.
    inv0 = match0 && oc_q[OC_INV0_BIT] && os_allow0;
    inv1 = match1 && oc_q[OC_INV1_BIT] && os_allow1;
    toggle = inv0 ^ inv1;

    // Timer output flip-flop.
    // The disable wins over presets, and a preset wins over a match in the same cycle.
    // Two inversions in one cycle cancel, so the level is left as it was.
    if (!oc_q[OC_TOE_BIT]) begin
      out_d = 1'b0;
    end else if (pre_lo && !pre_hi) begin
      out_d = 1'b0;
    end else if (pre_hi && !pre_lo) begin
      out_d = 1'b1;
    end else begin
      out_d = out_q ^ toggle;
    end

    // Register writes.
    // Writes to unmapped addresses are ignored.
    dir_d = dir_q;
    alt_d = alt_q;
    pre_d = pre_q;
    oc_d = oc_q;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PORT0_DIR: dir_d = (reg_wdata & DIR_STORE_MASK) | DIR_FIXED_ONES;
        ADDR_ALT_SEL: alt_d = reg_wdata;
        ADDR_PRESCALER: pre_d = reg_wdata & PR_STORE_MASK;
        // Trigger bits are not stored, so they read as zero.
        ADDR_OUT_CTRL: oc_d = reg_wdata & OC_STORE_MASK;
        default: ;
      endcase
    end

    // Register reads answer one cycle later; unmapped reads return zero.
    // Without a new read the last answer stays on the read data.
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PORT0_DIR: rdata_d = dir_q;
        ADDR_ALT_SEL: rdata_d = alt_q;
        ADDR_PRESCALER: rdata_d = pre_q;
        ADDR_OUT_CTRL: rdata_d = oc_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // All state returns to its value after reset on a synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= RST_PORT0_DIR;
      alt_q <= RST_ALT_SEL;
      pre_q <= RST_PRESCALER;
      oc_q <= RST_OUT_CTRL;
      rdata_q <= 8'h00;
      div_q <= '0;
      cnt_q <= '0;
      out_q <= 1'b0;
      m0_q <= 1'b0;
      m1_q <= 1'b0;
      os_q <= TMO_OS_IDLE;
    end else begin
      dir_q <= dir_d;
      alt_q <= alt_d;
      pre_q <= pre_d;
      oc_q <= oc_d;
      rdata_q <= rdata_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      m0_q <= m0_d;
      m1_q <= m1_d;
      os_q <= os_d;
    end
  end

  // Data outputs come straight from flip-flops.
  assign reg_rdata = rdata_q;
  assign count_value = cnt_q;
  assign match0_irq = m0_q;
  assign match1_irq = m1_q;
  assign timer_out_pin = out_q;

  // Pin zero can only ever drive low here; pin one carries the timer output.
  // The pin direction bits pass straight to the pad enables, low meaning drive.
  assign port_pin0_out = 1'b0;
  assign port_pin0_oe_n = dir_q[DIR_PIN0];
  assign port_pin1_out = out_q;
  assign port_pin1_oe_n = dir_q[DIR_PIN1];

endmodule : tmo_timer_out

// file: tmo_timer_out_chk.sv
`timescale 1ns/100ps
module tmo_chk
  import tmo_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] op_mode,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic match0_irq,
  input wire logic match1_irq,
  input wire logic timer_out_pin
);
  logic wr_oc;
  logic [7:0] oc_q;
  logic [7:0] oc_d;
  assign wr_oc = reg_wr && reg_addr == ADDR_OUT_CTRL;
  always_comb begin
    oc_d = rst ? 8'h00 : (wr_oc ? reg_wdata : oc_q);
  end
  always_ff @(posedge clk) begin
    oc_q <= oc_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  oc_read_zero_a: assert property (
    reg_rd && reg_addr == ADDR_OUT_CTRL |=> reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0)
    else $error("trigger bits read as one");
  inv0_match_a: assert property (
    match0_irq && !match1_irq && oc_q[0] && !oc_q[5] && !$past(wr_oc)
    |-> (timer_out_pin ^ $past(timer_out_pin)) == oc_q[1])
    else $error("compare zero toggle wrong");
  inv1_match_a: assert property (
    match1_irq && !match0_irq && oc_q[0] && !oc_q[5] && !$past(wr_oc)
    |-> (timer_out_pin ^ $past(timer_out_pin)) == oc_q[4])
    else $error("compare one toggle wrong");
  out_off_low_a: assert property (
    !oc_q[0] && !$past(oc_q[0]) |-> !timer_out_pin)
    else $error("output high while disabled");
  preset_high_a: assert property (
    wr_oc && reg_wdata[3:2] == 2'h2 && reg_wdata[0] && oc_q[0] |=> timer_out_pin)
    else $error("high preset missed");
  preset_low_a: assert property (
    wr_oc && reg_wdata[3:2] == 2'h1 && reg_wdata[0] && oc_q[0] |=> !timer_out_pin)
    else $error("low preset missed");
  preset_both_a: assert property (
    wr_oc && reg_wdata[3:2] == 2'h3 && reg_wdata[0] && oc_q[0] && op_mode == TMO_MODE_STOP
    && $past(op_mode) == TMO_MODE_STOP |=> $stable(timer_out_pin))
    else $error("both presets changed output");
  stop_clear_a: assert property (
    op_mode == TMO_MODE_STOP && $past(op_mode) == TMO_MODE_STOP |-> count_value == '0)
    else $error("count not zero when stopped");
endmodule : tmo_chk

bind tmo_timer_out tmo_chk #(.CNT_W(CNT_W)) chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .op_mode(op_mode), .count_value(count_value), .match0_irq(match0_irq),
  .match1_irq(match1_irq), .timer_out_pin(timer_out_pin));
